// ==== include/udcfg_consts.vh ====
// Purpose: Constants for the device configuration option block
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes:   Offsets are byte addresses of aligned words
`ifndef UDCFG_CONSTS_VH
`define UDCFG_CONSTS_VH

`define UDCFG_OFS_CONFIG        12'h000
`define UDCFG_OFS_CONTROL       12'h004
`define UDCFG_OFS_STATUS        12'h008
`define UDCFG_OFS_IRQ_STATUS    12'h00C
`define UDCFG_OFS_IRQ_CLEAR     12'h010
`define UDCFG_OFS_IRQ_ENABLE    12'h014

`define UDCFG_CFG_RESET         32'h00000000
`define UDCFG_CFG_MASK          32'h000FFFFF
`define UDCFG_BIT_SETDESC       18
`define UDCFG_BIT_REPRG_HOLD    17
`define UDCFG_BIT_HALT_REPLY    16
`define UDCFG_HS_TRIM_HI        15
`define UDCFG_HS_TRIM_LO        13
`define UDCFG_FS_TRIM_HI        12
`define UDCFG_FS_TRIM_LO        10
`define UDCFG_BIT_STUCK_DET     9
`define UDCFG_BIT_STAT_HI       8
`define UDCFG_BIT_STAT_LO       7
`define UDCFG_BIT_REPRG_DONE    13

`define UDCFG_HS_BASE_BITS      736
`define UDCFG_HS_MAX_BITS       848
`define UDCFG_FS_BASE_BITS      16
`define UDCFG_FS_MAX_BITS       18
`define UDCFG_STUCK_TIME_US     2000
`define UDCFG_MCLK_MHZ          40
`define UDCFG_STUCK_CYCLES      (`UDCFG_STUCK_TIME_US * `UDCFG_MCLK_MHZ)

`define UDCFG_HS_NAK            2'h0
`define UDCFG_HS_ACK            2'h1
`define UDCFG_HS_STALL          2'h2
`define UDCFG_HS_FWD            2'h3

`define UDCFG_EV_STUCK          0
`define UDCFG_EV_SETDESC        1
`define UDCFG_EV_CFGREQ         2
`define UDCFG_EV_BITS           3

`endif

// ==== src/udcfg_timeout.v ====
// Purpose: Bus turnaround timeout counter on link clock edges
// Assumes: linkTick is a one-cycle pulse per rising link clock edge
// Notes:   Base count plus trim value of extra link clocks
`timescale 1ns/1ps
`include "udcfg_consts.vh"
module udcfg_timeout #(
   parameter HS_BASE = `UDCFG_HS_BASE_BITS,
   parameter FS_BASE = `UDCFG_FS_BASE_BITS
) (
   input  wire        mclk,
   input  wire        reset,
   input  wire        linkTick,
   input  wire        start,
   input  wire        highSpeed,
   input  wire [2:0]  trim,
   output reg         expired
);
   reg  [9:0] count_reg;
   reg        run_reg;
   wire [9:0] limit;

   assign limit = (highSpeed ? HS_BASE[9:0] : FS_BASE[9:0]) + {7'h00, trim};

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         count_reg <= 10'h000;
         run_reg   <= 1'b0;
         expired   <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            count_reg <= 10'h000;
            run_reg   <= 1'b1;
         end else if (run_reg && linkTick) begin
            if (count_reg + 10'h001 >= limit) begin
               run_reg <= 1'b0;
               expired <= 1'b1;
            end
            count_reg <= count_reg + 10'h001;
         end
      end
   end
endmodule // udcfg_timeout

// ==== src/udcfg_top.v ====
// Purpose: Endpoint 0 reply policy and link timeouts set by the config register
// Assumes: AHB-Lite slave, single word transfers, link inputs asynchronous
// Notes:   Status-OUT reply: bits 8,7 both set gives STALL, otherwise ACK
`timescale 1ns/1ps
`include "udcfg_consts.vh"
module udcfg_top #(
   parameter STUCK_CYCLES = `UDCFG_STUCK_CYCLES,
   parameter HS_CAPABLE   = 1
) (
   input  wire        mclk,
   input  wire        reset,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   output wire        irq,
   input  wire        linkClk,
   input  wire        rxValid,
   input  wire        rxActive,
   input  wire        highSpeed,
   input  wire        turnStart,
   output wire        turnTimeout,
   input  wire        reqValid,
   input  wire        reqSetDesc,
   input  wire        reqSetCfg,
   input  wire        reqClearHaltEp0,
   input  wire        statusInStage,
   input  wire        statusOutData,
   output reg         replyValid,
   output reg  [1:0]  replyCode,
   output reg         setupForward
);
   reg  [31:0] config_reg;
   reg  [31:0] config_next;
   reg  [2:0]  irqStatus_reg;
   reg  [2:0]  irqEnable_reg;
   reg         holdPending_reg;
   reg         phyError_reg;
   reg  [11:0] addr_reg;
   reg         wrPhase_reg;
   reg         rdPhase_reg;
   reg  [2:0]  linkSync_reg;
   reg  [1:0]  rxValidSync_reg;
   reg  [1:0]  rxActiveSync_reg;
   reg  [23:0] stuckCount_reg;
   reg         cfgPending_reg;
   reg  [2:0]  evSet;
   reg  [2:0]  evClear;
   wire        addrPhase;
   wire        linkTick;
   wire        rxBusy;
   wire        stuckEnable;
   wire [2:0]  hsTrim;
   wire [2:0]  fsTrim;
   wire        doneWrite;

   assign addrPhase = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = |(irqStatus_reg & irqEnable_reg);

   // Variant without high speed sees these fields as zero
   assign hsTrim = HS_CAPABLE ? config_reg[`UDCFG_HS_TRIM_HI:`UDCFG_HS_TRIM_LO] : 3'h0;
   assign fsTrim = HS_CAPABLE ? config_reg[`UDCFG_FS_TRIM_HI:`UDCFG_FS_TRIM_LO] : 3'h0;
   assign stuckEnable = HS_CAPABLE ? config_reg[`UDCFG_BIT_STUCK_DET] : 1'b0;

   // AHB address phase capture
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         addr_reg    <= 12'h000;
         wrPhase_reg <= 1'b0;
         rdPhase_reg <= 1'b0;
      end else begin
         wrPhase_reg <= 1'b0;
         rdPhase_reg <= 1'b0;
         if (addrPhase) begin
            addr_reg    <= haddr;
            wrPhase_reg <= hwrite;
            rdPhase_reg <= !hwrite;
         end
      end
   end

   assign doneWrite = wrPhase_reg && (addr_reg == `UDCFG_OFS_CONTROL) &&
                      hwdata[`UDCFG_BIT_REPRG_DONE];

   always @* begin
      config_next = config_reg;
      if (wrPhase_reg && addr_reg == `UDCFG_OFS_CONFIG)
         config_next = hwdata & `UDCFG_CFG_MASK;
   end

   // Registers and read data
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         config_reg    <= `UDCFG_CFG_RESET;
         irqEnable_reg <= 3'h0;
         hrdata        <= 32'h00000000;
      end else begin
         config_reg <= config_next;
         if (wrPhase_reg && addr_reg == `UDCFG_OFS_IRQ_ENABLE)
            irqEnable_reg <= hwdata[2:0];
         if (addrPhase && !hwrite) begin
            case (haddr)
               `UDCFG_OFS_CONFIG:     hrdata <= config_next;
               `UDCFG_OFS_STATUS:     hrdata <= {29'h0, cfgPending_reg, holdPending_reg,
                                                 phyError_reg};
               `UDCFG_OFS_IRQ_STATUS: hrdata <= {29'h0, irqStatus_reg};
               `UDCFG_OFS_IRQ_ENABLE: hrdata <= {29'h0, irqEnable_reg};
               default:               hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Sticky events; set wins over clear
   always @* begin
      evSet = 3'h0;
      evSet[`UDCFG_EV_STUCK]   = stuckEnable && (stuckCount_reg == STUCK_CYCLES[23:0] - 24'h1)
                                 && rxBusy;
      evSet[`UDCFG_EV_SETDESC] = reqValid && reqSetDesc && config_reg[`UDCFG_BIT_SETDESC];
      evSet[`UDCFG_EV_CFGREQ]  = reqValid && reqSetCfg && !statusInStage;
      evClear = (wrPhase_reg && addr_reg == `UDCFG_OFS_IRQ_CLEAR) ? hwdata[2:0] : 3'h0;
   end

   always @(posedge mclk or posedge reset) begin
      if (reset)
         irqStatus_reg <= 3'h0;
      else
         irqStatus_reg <= (irqStatus_reg & ~evClear) | evSet;
   end

   // Link clock and receive lines pass two flops first
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         linkSync_reg     <= 3'h0;
         rxValidSync_reg  <= 2'h0;
         rxActiveSync_reg <= 2'h0;
      end else begin
         linkSync_reg     <= {linkSync_reg[1:0], linkClk};
         rxValidSync_reg  <= {rxValidSync_reg[0], rxValid};
         rxActiveSync_reg <= {rxActiveSync_reg[0], rxActive};
      end
   end

   assign linkTick = linkSync_reg[1] && !linkSync_reg[2];
   assign rxBusy   = rxValidSync_reg[1] || rxActiveSync_reg[1];

   // Continuous receive activity counter, saturating
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         stuckCount_reg <= 24'h000000;
         phyError_reg   <= 1'b0;
      end else begin
         if (!rxBusy || !stuckEnable)
            stuckCount_reg <= 24'h000000;
         else if (stuckCount_reg != STUCK_CYCLES[23:0])
            stuckCount_reg <= stuckCount_reg + 24'h000001;
         if (evSet[`UDCFG_EV_STUCK])
            phyError_reg <= 1'b1;
         else if (evClear[`UDCFG_EV_STUCK])
            phyError_reg <= 1'b0;
      end
   end

   udcfg_timeout u_timeout (
      .mclk      (mclk),
      .reset     (reset),
      .linkTick  (linkTick),
      .start     (turnStart),
      .highSpeed (highSpeed),
      .trim      (highSpeed ? hsTrim : fsTrim),
      .expired   (turnTimeout)
   );

   // Status IN hold after configuration requests
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         holdPending_reg <= 1'b0;
         cfgPending_reg  <= 1'b0;
      end else begin
         if (reqValid && reqSetCfg && !statusInStage) begin
            cfgPending_reg  <= 1'b1;
            holdPending_reg <= config_reg[`UDCFG_BIT_REPRG_HOLD];
         end else if (doneWrite) begin
            holdPending_reg <= 1'b0;
            cfgPending_reg  <= 1'b0;
         end else if (reqValid && reqSetCfg && statusInStage && !holdPending_reg) begin
            cfgPending_reg  <= 1'b0;
         end
      end
   end

   // Handshake decision, one cycle after the request
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         replyValid   <= 1'b0;
         replyCode    <= `UDCFG_HS_ACK;
         setupForward <= 1'b0;
      end else begin
         replyValid   <= reqValid;
         setupForward <= 1'b0;
         if (reqValid) begin
            if (reqSetDesc) begin
               if (config_reg[`UDCFG_BIT_SETDESC]) begin
                  replyCode    <= `UDCFG_HS_FWD;
                  setupForward <= 1'b1;
               end else
                  replyCode <= `UDCFG_HS_STALL;
            end else if (reqSetCfg && statusInStage)
               replyCode <= holdPending_reg && !doneWrite ? `UDCFG_HS_NAK : `UDCFG_HS_ACK;
            else if (reqClearHaltEp0)
               replyCode <= config_reg[`UDCFG_BIT_HALT_REPLY] ? `UDCFG_HS_STALL
                                                              : `UDCFG_HS_ACK;
            else if (statusOutData)
               replyCode <= (config_reg[`UDCFG_BIT_STAT_HI] && config_reg[`UDCFG_BIT_STAT_LO])
                            ? `UDCFG_HS_STALL : `UDCFG_HS_ACK;
            else
               replyCode <= `UDCFG_HS_ACK;
         end
      end
   end
endmodule // udcfg_top

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for udcfg_top
// Assumes: 40 MHz mclk, link clock from the host model
// Notes:   Expectations queued, a monitor compares
`timescale 1ns/1ps
module tb_top;
   logic        mclk, reset, hsel, hwrite, highSpeed, turnStart, rdPh, lk;
   logic [1:0]  htrans;
   logic [2:0]  hsize, trim;
   logic [11:0] haddr;
   logic [31:0] hwdata, d;
   wire  [31:0] hrdata;
   wire  [1:0]  replyCode;
   wire         hreadyout, hresp, irq, turnTimeout, replyValid, setupForward, linkClk;
   wire         rxValid, rxActive, reqValid, reqSetDesc, reqSetCfg, reqClearHaltEp0;
   wire         statusInStage, statusOutData;
   wire         hready = hreadyout;
   logic [31:0] rdQ[$];
   logic [2:0]  rpQ[$];
   int          bad_count = 0, tests_run = 0, cyc = 0, edges, n;
   udcfg_top #(.STUCK_CYCLES(50)) udcfg_top_i (.*);
   udcfg_host_model udcfg_host_model_i (.*);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] v);
      if (!wr) rdQ.push_back(v);
      @(posedge mclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, a};
      do @(posedge mclk); while (!hreadyout);
      {hsel, htrans} <= 3'h0;
      hwdata <= wr ? v : 32'h0;
      do @(posedge mclk); while (!hreadyout);
   endtask
   task req(input logic [4:0] q, input logic [2:0] e);
      rpQ.push_back(e);
      udcfg_host_model_i.request(q);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         test_done;
      end
      rdPh <= hsel && htrans[1] && !hwrite && hready;
      if (rdPh && hready) check(hrdata, rdQ.pop_front());
      if (replyValid) check({setupForward, replyCode}, rpQ.pop_front());
   end
   always @(negedge mclk) lk <= linkClk;
   initial begin
      {reset, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 48'h0};
      {hsize, highSpeed, turnStart} = {3'h2, 2'h0};
      d = $urandom(52266);
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      bus(0, 12'h000, 32'h0);
      bus(0, 12'h0FC, 32'h0);
      d = $urandom;
      bus(1, 12'h000, d);
      bus(0, 12'h000, d & 32'h000FFFFF);
      $display("register test done");
      bus(1, 12'h000, 32'h0);
      req(5'h10, 3'h2);
      req(5'h04, 3'h1);
      bus(1, 12'h000, 32'h00050000);
      req(5'h10, 3'h7);
      req(5'h04, 3'h2);
      for (int i = 0; i < 4; i++) begin
         bus(1, 12'h000, i << 7);
         req(5'h01, i == 3 ? 3'h2 : 3'h1);
      end
      $display("reply test done");
      bus(1, 12'h014, 32'h7);
      bus(1, 12'h000, 32'h00020000);
      req(5'h08, 3'h1);
      req(5'h0A, 3'h0);
      req(5'h0A, 3'h0);
      bus(1, 12'h004, 32'h2000);
      req(5'h0A, 3'h1);
      bus(0, 12'h00C, 32'h6);
      #1 check(irq, 1);
      bus(1, 12'h010, 32'h7);
      #1 check(irq, 0);
      $display("hold test done");
      bus(1, 12'h014, 32'h0);
      bus(1, 12'h000, 32'h200);
      udcfg_host_model_i.busy(70, $urandom % 2);
      #1 check(irq, 0);
      bus(1, 12'h014, 32'h1);
      #1 check(irq, 1);
      bus(0, 12'h00C, 32'h1);
      bus(1, 12'h010, 32'h1);
      #1 check(irq, 0);
      $display("stuck test done");
      for (int hs = 0; hs < 2; hs++) begin
         trim = $urandom;
         bus(1, 12'h000, hs ? trim << 13 : trim << 10);
         n = (hs ? 736 : 16) + trim;
         highSpeed <= hs;
         @(posedge mclk);
         turnStart <= 1'b1;
         @(posedge mclk);
         turnStart <= 1'b0;
         edges = 0;
         do begin
            @(negedge mclk);
            if (linkClk && !lk) edges++;
         end while (!turnTimeout);
         check(edges >= n - 1 && edges <= n + 1, 1);
      end
      $display("timeout test done");
      test_done;
   end
endmodule // tb_top
bind udcfg_top udcfg_chk udcfg_chk_i (.*);

// ==== verification/udcfg_chk.sv ====
// Purpose: Port checks for udcfg_top
// Assumes: Bound to udcfg_top in tb_top
// Notes:   Shadows config bits 18 and 16 from bus writes
`timescale 1ns/1ps
module udcfg_chk (
   input wire logic        mclk, reset, hsel, hwrite, hready, hreadyout, hresp,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans, replyCode,
   input wire logic [31:0] hwdata,
   input wire logic        reqValid, reqSetDesc, reqSetCfg, reqClearHaltEp0,
   input wire logic        statusInStage, replyValid, setupForward, turnStart, turnTimeout
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic        wrPh, sdBit, haltBit;
   logic [11:0] wrAddr;
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         wrPh    <= 1'b0;
         wrAddr  <= 12'h000;
         sdBit   <= 1'b0;
         haltBit <= 1'b0;
      end else begin
         wrPh   <= hsel && hready && htrans[1] && hwrite;
         wrAddr <= haddr;
         if (wrPh && wrAddr == 12'h000) begin
            sdBit   <= hwdata[18];
            haltBit <= hwdata[16];
         end
      end
   end
   sequence descReq; reqValid && reqSetDesc; endsequence
   sequence haltReq; reqValid && !reqSetDesc && !reqSetCfg && reqClearHaltEp0; endsequence
   sequence cfgStatReq; reqValid && !reqSetDesc && reqSetCfg && statusInStage; endsequence
   a_reply_next: assert property (reqValid |=> replyValid)
      else $error("no reply after request");
   a_reply_once: assert property (!reqValid |=> !replyValid)
      else $error("reply without request");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_fwd_code: assert property (setupForward |-> replyValid && replyCode == 2'h3)
      else $error("forward without forward code");
   a_desc_reply: assert property (descReq |=> replyCode == (sdBit ? 2'h3 : 2'h2))
      else $error("set descriptor reply wrong");
   a_halt_reply: assert property (haltReq |=> replyCode == (haltBit ? 2'h2 : 2'h1))
      else $error("clear halt reply wrong");
   a_cfg_status: assert property (cfgStatReq |=> replyCode inside {2'h0, 2'h1})
      else $error("status in reply neither nak nor ack");
   a_timeout_wait: assert property (turnStart |=> !turnTimeout [*8])
      else $error("timeout too early");
endmodule // udcfg_chk

// ==== verification/udcfg_host_model.sv ====
// Purpose: Host side seen through the transceiver
// Assumes: Requests launched just after mclk edges
// Notes:   Transceiver clock runs free
`timescale 1ns/1ps
module udcfg_host_model (
   input wire logic mclk,
   output logic     linkClk, rxValid, rxActive, reqValid, reqSetDesc, reqSetCfg,
   output logic     reqClearHaltEp0, statusInStage, statusOutData
);
   initial begin
      {linkClk, rxValid, rxActive, reqValid} = 4'h0;
      {reqSetDesc, reqSetCfg, reqClearHaltEp0, statusInStage, statusOutData} = 5'h00;
      #37;
      forever #100 linkClk = ~linkClk;
   end
   task request(input logic [4:0] q);
      @(posedge mclk);
      reqValid <= 1'b1;
      {reqSetDesc, reqSetCfg, reqClearHaltEp0, statusInStage, statusOutData} <= q;
      @(posedge mclk);
      reqValid <= 1'b0;
      // Stale qualifiers are shown inverted
      {reqSetDesc, reqSetCfg, reqClearHaltEp0, statusInStage, statusOutData} <= ~q;
   endtask
   task busy(input int n, input logic v);
      @(posedge mclk);
      rxValid  <= v;
      rxActive <= !v;
      repeat (n) @(posedge mclk);
      {rxValid, rxActive} <= 2'h0;
   endtask
endmodule // udcfg_host_model
